// File: hw/dma_pkg.sv
// constants and types for the five-channel memory mover
package dma_pkg;
  localparam int          NUM_CH         = 5;
  localparam logic [2:0]  ADDR_ARM       = 3'h0;
  localparam logic [2:0]  ADDR_REQ       = 3'h1;
  localparam logic [2:0]  ADDR_FLAG      = 3'h2;
  localparam logic [2:0]  ADDR_P0_HI     = 3'h3;
  localparam logic [2:0]  ADDR_P0_LO     = 3'h4;
  localparam logic [2:0]  ADDR_P1_HI     = 3'h5;
  localparam logic [2:0]  ADDR_P1_LO     = 3'h6;
  localparam int          ABORT_BIT      = 7;
  localparam logic [15:0] DESC_BYTES     = 16'h0008;
  localparam logic [1:0]  MODE_SINGLE    = 2'h0;
  localparam logic [1:0]  MODE_BLOCK     = 2'h1;
  localparam logic [1:0]  MODE_RSINGLE   = 2'h2;
  localparam logic [1:0]  MODE_RBLOCK    = 2'h3;
  localparam logic [1:0]  STEP_HOLD      = 2'h0;
  localparam logic [1:0]  STEP_PLUS1     = 2'h1;
  localparam logic [1:0]  STEP_PLUS2     = 2'h2;
  localparam logic [1:0]  STEP_MINUS1    = 2'h3;
  localparam logic [1:0]  PRIO_LOW       = 2'h0;
  localparam logic [1:0]  PRIO_NORMAL    = 2'h1;
  localparam logic [1:0]  PRIO_HIGH      = 2'h2;
  localparam logic [4:0]  TRIGGER_SELECT_FIELD_NONE      = 5'h00;
  localparam logic [4:0]  TRIGGER_SELECT_FIELD_PREV      = 5'h01;
  localparam logic [7:0]  REG_RESET      = 8'h00;
  typedef enum logic [2:0] {S_IDLE, S_FETCH, S_RDLO, S_RDHI, S_WRLO, S_WRHI} eng_t;
endpackage : dma_pkg

// File: hw/dma_desc_mem.sv
// descriptor store: eight bytes per channel, registered read port
`timescale 1ns/1ps
module dma_desc_mem #(
  parameter int DEPTH = 40
) (
  input  wire logic       clk,
  input  wire logic       we,
  input  wire logic [5:0] waddr,
  input  wire logic [7:0] wdata,
  input  wire logic [5:0] raddr,
  output logic      [7:0] rdata
);
  logic [7:0] mem [DEPTH];
  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule : dma_desc_mem

// File: hw/dma_engine.sv
// five-channel memory mover: register port, descriptor fetch, arbitration, transfers
`timescale 1ns/1ps
module dma_engine (
  input  wire logic        CORE_CLK,
  input  wire logic        RST,
  input  wire logic [2:0]  REG_ADDR,
  input  wire logic [7:0]  REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic      [7:0]  REG_RDATA,
  input  wire logic [31:0] TRIGGER_SELECT_FIELD_IN,
  input  wire logic        CPU_REQ,
  output logic             CPU_GNT,
  output logic             MEM_REQ,
  output logic             MEM_WE,
  output logic      [15:0] MEM_ADDR,
  output logic      [7:0]  MEM_WDATA,
  input  wire logic [7:0]  MEM_RDATA,
  output logic             IRQ
);
  localparam int N = dma_pkg::NUM_CH;
  // per-channel descriptor fields, latched at fetch
  logic [15:0] src_r [N];
  logic [15:0] dst_r [N];
  logic [15:0] sp_r  [N];
  logic [15:0] dp_r  [N];
  logic [12:0] len_r [N];
  logic [12:0] cnt_r [N];
  logic [7:0]  cfg6_r [N];
  logic [7:0]  cfg7_r [N];
  logic [N-1:0] arm_r, act_r, pend_r, flag_r, fetched_r, done_r;
  logic [7:0]  p0h_r, p0l_r, p1h_r, p1l_r, rdata_r;
  logic [2:0]  rr_r;
  logic        cpu_skip_r;
  dma_pkg::eng_t st_r;
  logic [2:0]  ch_r;
  logic [2:0]  fidx_r;
  logic [7:0]  dlo_r, dhi_r;
  logic [15:0] fbase;
  logic [N-1:0] set_arm;
  logic        abort_wr;
  logic        dm_we;
  logic [7:0]  dm_rd;

  // descriptor mirror: bytes pass through the memory bus and are kept locally
  dma_desc_mem #(.DEPTH(8*N)) u_desc (
    .clk   (CORE_CLK),
    .we    (dm_we),
    .waddr ({ch_r, fidx_r}),
    .wdata (MEM_RDATA),
    .raddr ({ch_r, 3'h7}),
    .rdata (dm_rd)
  );

  function automatic logic [15:0] step(input logic [15:0] a, input logic [1:0] m);
    case (m)
      dma_pkg::STEP_PLUS1:  step = a + 16'h0001;
      dma_pkg::STEP_PLUS2:  step = a + 16'h0002;
      dma_pkg::STEP_MINUS1: step = a - 16'h0001;
      default:              step = a;
    endcase
  endfunction : step

  function automatic logic [1:0] prio(input logic [7:0] c7);
    prio = c7[1:0];
  endfunction : prio

  assign abort_wr = REG_WR && REG_ADDR == dma_pkg::ADDR_ARM && REG_WDATA[dma_pkg::ABORT_BIT];
  assign set_arm  = (REG_WR && REG_ADDR == dma_pkg::ADDR_ARM && !abort_wr) ?
                    REG_WDATA[N-1:0] : '0;

  // trigger decode and request collection
  logic [N-1:0] trigger_select_field_hit, ready;
  always_comb
  begin
    for (int i = 0; i < N; i++)
    begin
      logic [4:0] t;
      t = cfg6_r[i][4:0];
      if (t == dma_pkg::TRIGGER_SELECT_FIELD_NONE)
        trigger_select_field_hit[i] = 1'b0;
      else if (t == dma_pkg::TRIGGER_SELECT_FIELD_PREV)
        trigger_select_field_hit[i] = done_r[(i + N - 1) % N];
      else
        trigger_select_field_hit[i] = TRIGGER_SELECT_FIELD_IN[t];
      ready[i] = arm_r[i] && fetched_r[i] && (act_r[i] || pend_r[i]);
    end
  end

  // arbitration: highest level wins, rotation breaks ties
  logic [2:0] win;
  logic       win_v;
  logic [1:0] win_p;
  always_comb
  begin
    win = 3'h0;
    win_v = 1'b0;
    win_p = dma_pkg::PRIO_LOW;
    for (int k = 0; k < N; k++)
    begin
      int c;
      c = (int'(rr_r) + 1 + k) % N;
      if (ready[c] && (!win_v || prio(cfg7_r[c]) > win_p))
      begin
        win = c[2:0];
        win_v = 1'b1;
        win_p = prio(cfg7_r[c]);
      end
    end
  end

  // need to fetch: armed without descriptor
  logic [N-1:0] need_f;
  logic [2:0]   fch;
  logic         fv;
  always_comb
  begin
    need_f = arm_r & ~fetched_r;
    fch = 3'h0;
    fv = 1'b0;
    for (int i = N - 1; i >= 0; i--)
      if (need_f[i])
      begin
        fch = i[2:0];
        fv = 1'b1;
      end
    // follow the channel being fetched, not the one that would be picked next
    fbase = (ch_r == 3'h0) ? {p0h_r, p0l_r} :
            {p1h_r, p1l_r} + {10'h000, ch_r - 3'h1, 3'h0};
  end

  // processor conflict resolution per level
  logic dma_go;
  always_comb
  begin
    if (!CPU_REQ)
      dma_go = 1'b1;
    else if (st_r == dma_pkg::S_FETCH || st_r == dma_pkg::S_IDLE)
      dma_go = 1'b0;
    else
      case (prio(cfg7_r[ch_r]))
        dma_pkg::PRIO_HIGH:   dma_go = 1'b1;
        dma_pkg::PRIO_NORMAL: dma_go = cpu_skip_r;
        default:              dma_go = 1'b0;
      endcase
  end
  assign CPU_GNT = CPU_REQ && !(MEM_REQ && dma_go);

  logic word;
  logic [12:0] eff_len;
  assign word    = cfg6_r[ch_r][7];
  // fixed length used; variable-length field kept in bit 2 of byte 7 as width select
  assign eff_len = (!word && !cfg7_r[ch_r][2]) ? {6'h00, len_r[ch_r][6:0]} : len_r[ch_r];

  always_comb
  begin
    MEM_REQ = 1'b0;
    MEM_WE = 1'b0;
    MEM_ADDR = 16'h0000;
    MEM_WDATA = 8'h00;
    case (st_r)
      dma_pkg::S_FETCH:
      begin
        MEM_REQ = !CPU_REQ;
        MEM_ADDR = fbase + {13'h0000, fidx_r};
      end
      dma_pkg::S_RDLO:
      begin
        MEM_REQ = 1'b1;
        MEM_ADDR = sp_r[ch_r];
      end
      dma_pkg::S_RDHI:
      begin
        MEM_REQ = 1'b1;
        MEM_ADDR = sp_r[ch_r] + 16'h0001;
      end
      dma_pkg::S_WRLO:
      begin
        MEM_REQ = 1'b1;
        MEM_WE = 1'b1;
        MEM_ADDR = dp_r[ch_r];
        MEM_WDATA = dlo_r;
      end
      dma_pkg::S_WRHI:
      begin
        MEM_REQ = 1'b1;
        MEM_WE = 1'b1;
        MEM_ADDR = dp_r[ch_r] + 16'h0001;
        MEM_WDATA = dhi_r;
      end
      default: ;
    endcase
  end

  logic go;
  assign go = MEM_REQ && dma_go;
  assign dm_we = go && st_r == dma_pkg::S_FETCH;

  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      st_r <= dma_pkg::S_IDLE;
      arm_r <= '0;
      act_r <= '0;
      pend_r <= '0;
      flag_r <= '0;
      fetched_r <= '0;
      done_r <= '0;
      p0h_r <= dma_pkg::REG_RESET;
      p0l_r <= dma_pkg::REG_RESET;
      p1h_r <= dma_pkg::REG_RESET;
      p1l_r <= dma_pkg::REG_RESET;
      rdata_r <= dma_pkg::REG_RESET;
      rr_r <= 3'h0;
      cpu_skip_r <= 1'b0;
      ch_r <= 3'h0;
      fidx_r <= 3'h0;
      dlo_r <= 8'h00;
      dhi_r <= 8'h00;
      IRQ <= 1'b0;
      for (int i = 0; i < N; i++)
      begin
        src_r[i] <= 16'h0000;
        dst_r[i] <= 16'h0000;
        sp_r[i] <= 16'h0000;
        dp_r[i] <= 16'h0000;
        len_r[i] <= 13'h0000;
        cnt_r[i] <= 13'h0000;
        cfg6_r[i] <= 8'h00;
        cfg7_r[i] <= 8'h00;
      end
    end
    else
    begin
      logic [N-1:0] fl_set, dn;
      fl_set = '0;
      dn = '0;
      // conflict bookkeeping for the every-second-try guarantee
      if (CPU_REQ && MEM_REQ && st_r != dma_pkg::S_FETCH)
        cpu_skip_r <= !dma_go;
      for (int i = 0; i < N; i++)
        if (arm_r[i] && fetched_r[i] && trigger_select_field_hit[i])
          pend_r[i] <= 1'b1;
      if (REG_WR && REG_ADDR == dma_pkg::ADDR_REQ)
        pend_r <= pend_r | (REG_WDATA[N-1:0] & arm_r) | (trigger_select_field_hit & arm_r & fetched_r);
      case (st_r)
        dma_pkg::S_IDLE:
          if (fv)
          begin
            ch_r <= fch;
            fidx_r <= 3'h0;
            st_r <= dma_pkg::S_FETCH;
          end
          else if (win_v)
          begin
            ch_r <= win;
            rr_r <= win;
            act_r[win] <= 1'b1;
            pend_r[win] <= 1'b0;
            st_r <= dma_pkg::S_RDLO;
          end
        dma_pkg::S_FETCH:
          if (go)
          begin
            case (fidx_r)
              3'h0: src_r[ch_r][15:8] <= MEM_RDATA;
              3'h1: src_r[ch_r][7:0] <= MEM_RDATA;
              3'h2: dst_r[ch_r][15:8] <= MEM_RDATA;
              3'h3: dst_r[ch_r][7:0] <= MEM_RDATA;
              3'h4: len_r[ch_r][12:8] <= MEM_RDATA[4:0];
              3'h5: len_r[ch_r][7:0] <= MEM_RDATA;
              3'h6: cfg6_r[ch_r] <= MEM_RDATA;
              default: cfg7_r[ch_r] <= MEM_RDATA;
            endcase
            fidx_r <= fidx_r + 3'h1;
            if (fidx_r == 3'h7)
            begin
              sp_r[ch_r] <= src_r[ch_r];
              dp_r[ch_r] <= dst_r[ch_r];
              cnt_r[ch_r] <= 13'h0000;
              fetched_r[ch_r] <= 1'b1;
              st_r <= dma_pkg::S_IDLE;
            end
          end
        dma_pkg::S_RDLO:
          if (go)
          begin
            dlo_r <= MEM_RDATA;
            st_r <= word ? dma_pkg::S_RDHI : dma_pkg::S_WRLO;
          end
        dma_pkg::S_RDHI:
          if (go)
          begin
            dhi_r <= MEM_RDATA;
            st_r <= dma_pkg::S_WRLO;
          end
        dma_pkg::S_WRLO:
          if (go)
            st_r <= word ? dma_pkg::S_WRHI : dma_pkg::S_WRLO;
        default: ;
      endcase
      // end of a unit transfer
      if (go && ((st_r == dma_pkg::S_WRLO && !word) || st_r == dma_pkg::S_WRHI))
      begin
        logic [12:0] nc;
        logic [1:0]  md;
        nc = cnt_r[ch_r] + 13'h0001;
        md = cfg6_r[ch_r][6:5];
        sp_r[ch_r] <= step(sp_r[ch_r], cfg7_r[ch_r][7:6]);
        dp_r[ch_r] <= step(dp_r[ch_r], cfg7_r[ch_r][5:4]);
        cnt_r[ch_r] <= nc;
        st_r <= dma_pkg::S_IDLE;
        if (md == dma_pkg::MODE_SINGLE || md == dma_pkg::MODE_RSINGLE)
          act_r[ch_r] <= 1'b0;
        if (nc >= eff_len)
        begin
          act_r[ch_r] <= 1'b0;
          fl_set[ch_r] = 1'b1;
          dn[ch_r] = 1'b1;
          if (md == dma_pkg::MODE_SINGLE || md == dma_pkg::MODE_BLOCK)
            arm_r[ch_r] <= 1'b0;
          fetched_r[ch_r] <= 1'b0; // refetch at once if still armed, else on rearm
        end
        // block modes stay active so the channel re-requests at once
      end
      done_r <= dn;
      if (abort_wr)
      begin
        arm_r <= arm_r & ~REG_WDATA[N-1:0];
        act_r <= act_r & ~REG_WDATA[N-1:0];
        pend_r <= pend_r & ~REG_WDATA[N-1:0];
        fetched_r <= fetched_r & ~REG_WDATA[N-1:0];
        if (st_r != dma_pkg::S_IDLE && REG_WDATA[ch_r])
          st_r <= dma_pkg::S_IDLE;
      end
      else if (|set_arm)
      begin
        arm_r <= arm_r | set_arm;
        fetched_r <= fetched_r & ~set_arm;
      end
      // set wins over a software clear in the same cycle
      if (REG_WR && REG_ADDR == dma_pkg::ADDR_FLAG)
        flag_r <= (flag_r & REG_WDATA[N-1:0]) | fl_set;
      else
        flag_r <= flag_r | fl_set;
      begin
        logic irq;
        irq = 1'b0;
        for (int i = 0; i < N; i++)
          irq = irq | (fl_set[i] && cfg7_r[i][3]);
        IRQ <= irq;
      end
      if (REG_WR)
        case (REG_ADDR)
          dma_pkg::ADDR_P0_HI: p0h_r <= REG_WDATA;
          dma_pkg::ADDR_P0_LO: p0l_r <= REG_WDATA;
          dma_pkg::ADDR_P1_HI: p1h_r <= REG_WDATA;
          dma_pkg::ADDR_P1_LO: p1l_r <= REG_WDATA;
          default: ;
        endcase
      if (REG_RD)
        case (REG_ADDR)
          dma_pkg::ADDR_ARM:   rdata_r <= {3'h0, arm_r};
          dma_pkg::ADDR_REQ:   rdata_r <= {3'h0, pend_r};
          dma_pkg::ADDR_FLAG:  rdata_r <= {3'h0, flag_r};
          dma_pkg::ADDR_P0_HI: rdata_r <= p0h_r;
          dma_pkg::ADDR_P0_LO: rdata_r <= p0l_r;
          dma_pkg::ADDR_P1_HI: rdata_r <= p1h_r;
          dma_pkg::ADDR_P1_LO: rdata_r <= p1l_r;
          default:             rdata_r <= 8'h00;
        endcase
    end
  end
  assign REG_RDATA = rdata_r;

  high_beats_cpu_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    (MEM_REQ && st_r != dma_pkg::S_FETCH && prio(cfg7_r[ch_r]) == dma_pkg::PRIO_HIGH)
    |-> !CPU_GNT) else $error("high priority lost to processor");
  low_yields_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    (CPU_REQ && st_r != dma_pkg::S_FETCH && prio(cfg7_r[ch_r]) == dma_pkg::PRIO_LOW)
    |-> CPU_GNT) else $error("low priority beat processor");
  normal_share_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    (CPU_REQ && MEM_REQ && !dma_go && st_r != dma_pkg::S_FETCH && st_r != dma_pkg::S_IDLE
     && prio(cfg7_r[ch_r]) == dma_pkg::PRIO_NORMAL) ##1 (CPU_REQ && MEM_REQ
     && prio(cfg7_r[ch_r]) == dma_pkg::PRIO_NORMAL && $stable(st_r)) |-> dma_go)
    else $error("normal priority lost twice");
  abort_clears_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    abort_wr |=> ((arm_r & $past(REG_WDATA[N-1:0])) == '0)) else $error("abort missed");
  flag_sets_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    |done_r |-> ((flag_r & done_r) == done_r)) else $error("completion flag not set");
  unarmed_idle_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    (st_r == dma_pkg::S_IDLE && win_v) |-> arm_r[win]) else $error("unarmed channel ran");
  mem_idle_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    (st_r == dma_pkg::S_IDLE) |-> !MEM_REQ) else $error("bus used while idle");
  read_once_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    (st_r == dma_pkg::S_RDLO && go && !word) |=> st_r == dma_pkg::S_WRLO)
    else $error("byte transfer sequence broken");
  abort_cov_c: cover property (@(posedge CORE_CLK) abort_wr && |arm_r);
  done_cov_c: cover property (@(posedge CORE_CLK) |done_r);
  conflict_cov_c: cover property (@(posedge CORE_CLK) CPU_REQ && MEM_REQ);
endmodule : dma_engine

// File: dv/dma_mem_model.sv
// memory model standing on the far side of the mover's memory port
`timescale 1ns/1ps
module dma_mem_model (
  input  wire logic        clk,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [15:0] mem_addr,
  input  wire logic [7:0]  mem_wdata,
  input  wire logic        cpu_gnt,
  output logic      [7:0]  mem_rdata,
  output int               wr_cnt
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_r;

  initial
  begin
    wr_cnt = 0;
    last_r = 8'h00;
  end

  // a cycle the mover does not own shows no stale byte: the inverse of the last one served
  always_comb mem_rdata = (mem_req && !cpu_gnt) ? mem[mem_addr] : ~last_r;

  // the mover owns the memory only while the processor is not granted
  always @(posedge clk)
  begin
    if (mem_req && !cpu_gnt)
    begin
      last_r <= mem[mem_addr];
      if (mem_we)
      begin
        mem[mem_addr] <= mem_wdata;
        wr_cnt        <= wr_cnt + 1;
      end
    end
  end
endmodule : dma_mem_model

// File: dv/multichannel_dma_channel_engine_test.sv
// self-checking bench for the five-channel memory mover
`timescale 1ns/1ps
module multichannel_dma_channel_engine_test;
  logic        clk       = 1'b0;
  logic        rst       = 1'b1;
  logic [2:0]  reg_addr  = 3'h0;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic [31:0] trigger_select_field_in   = 32'h0;
  logic        cpu_req   = 1'b0;
  logic [7:0]  reg_rdata;
  logic        cpu_gnt;
  logic        mem_req;
  logic        mem_we;
  logic        irq;
  logic [15:0] mem_addr;
  logic [7:0]  mem_wdata;
  logic [7:0]  mem_rdata;
  logic [7:0]  v;
  logic [7:0]  ref_mem [int];
  int          wr_cnt;
  int          bad_count = 0;
  int          n_tests   = 0;
  int          irq_cnt   = 0;
  int          seed      = 37;

  always #5 clk = ~clk;
  always @(posedge clk) if (irq === 1'b1) irq_cnt <= irq_cnt + 1;

  dma_engine dma_engine_inst (
    .CORE_CLK  (clk),
    .RST       (rst),
    .REG_ADDR  (reg_addr),
    .REG_WDATA (reg_wdata),
    .REG_WR    (reg_wr),
    .REG_RD    (reg_rd),
    .REG_RDATA (reg_rdata),
    .TRIGGER_SELECT_FIELD_IN   (trigger_select_field_in),
    .CPU_REQ   (cpu_req),
    .CPU_GNT   (cpu_gnt),
    .MEM_REQ   (mem_req),
    .MEM_WE    (mem_we),
    .MEM_ADDR  (mem_addr),
    .MEM_WDATA (mem_wdata),
    .MEM_RDATA (mem_rdata),
    .IRQ       (irq)
  );

  dma_mem_model dma_mem_model_inst (
    .clk       (clk),
    .mem_req   (mem_req),
    .mem_we    (mem_we),
    .mem_addr  (mem_addr),
    .mem_wdata (mem_wdata),
    .cpu_gnt   (cpu_gnt),
    .mem_rdata (mem_rdata),
    .wr_cnt    (wr_cnt)
  );

  task automatic print_verdict();
    if (bad_count == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : print_verdict

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    @(posedge clk);
    d = reg_rdata;
  endtask : rd

  task automatic pulse(input logic [31:0] t);
    @(posedge clk);
    trigger_select_field_in <= t;
    @(posedge clk);
    trigger_select_field_in <= 32'h0;
  endtask : pulse

  task automatic wait_wr(input int target);
    for (int i = 0; i < 200 && wr_cnt < target; i++) @(posedge clk);
    check(16'(wr_cnt >= target), 16'h1);
  endtask : wait_wr

  task automatic wait_flag(input int ch);
    v = 8'h00;
    for (int i = 0; i < 100 && v[ch] !== 1'b1; i++) rd(dma_pkg::ADDR_FLAG, v);
    check(16'(v[ch]), 16'h1);
  endtask : wait_flag

  // step codes 0..2 map to themselves, 3 walks backwards
  function automatic int stp(input int m);
    return (m == 3) ? -1 : m;
  endfunction : stp

  // one channel job: ch, mode, trigger (-1 random peripheral), count, steps, prio, irq, word, cpu
  task automatic run(input int ch, input int md, input int tg, input int ln, input int si,
                     input int di, input int pr, input int ie, input int ws, input int cp);
    int          s, d, w0, i0, nt, n;
    logic [15:0] base;
    logic [7:0]  desc [8];
    base = (ch == 0) ? 16'h0040 : 16'h0100 + 16'(8 * (ch - 1));
    if (tg < 0) tg = 2 + ($unsigned($random(seed)) % 29);
    // lengths above 127 run with the seven-bit length width
    n = (ln > 127) ? ln % 128 : ln;
    for (int a = 16'h0200; a < 16'h0300; a++)
    begin
      ref_mem[a] = 8'($random(seed));
      dma_mem_model_inst.mem[a] = ref_mem[a];
    end
    desc = '{8'h02, 8'h20, 8'h02, 8'ha0, 8'h00, 8'(ln), 8'(ws * 128 + md * 32 + tg),
             8'(si * 64 + di * 16 + ie * 8 + ((ln > 127) ? 0 : 4) + pr)};
    for (int i = 0; i < 8; i++) dma_mem_model_inst.mem[base + 16'(i)] = desc[i];
    s = 16'h0220;
    d = 16'h02a0;
    for (int i = 0; i < n; i++)
    begin
      ref_mem[d] = ref_mem[s];
      if (ws == 1) ref_mem[d + 1] = ref_mem[s + 1];
      s += stp(si);
      d += stp(di);
    end
    w0 = wr_cnt;
    i0 = irq_cnt;
    if (tg > 1) pulse(32'h1 << tg);
    wr(dma_pkg::ADDR_ARM, 8'h01 << ch);
    repeat (12) @(posedge clk);
    cpu_req <= cp[0];
    pulse(~(32'h1 << tg) & 32'hffff_fffc);
    repeat (10) @(posedge clk);
    check(16'(wr_cnt - w0), 16'h0);
    nt = (md % 2 == 0) ? n : 1;
    for (int k = 0; k < nt; k++)
    begin
      if (tg == 0) wr(dma_pkg::ADDR_REQ, 8'h01 << ch);
      else pulse(32'h1 << tg);
      if (pr == 0 && cp == 1)
      begin
        repeat (40) @(posedge clk);
        check(16'(wr_cnt - w0), 16'h0);
        cpu_req <= 1'b0;
      end
      if (nt > 1)
      begin
        wait_wr(w0 + k + 1);
        repeat (10) @(posedge clk);
        check(16'(wr_cnt - w0), 16'(k + 1));
      end
    end
    wait_wr(w0 + n * (ws + 1));
    wait_flag(ch);
    cpu_req <= 1'b0;
    check(16'(wr_cnt - w0), 16'(n * (ws + 1)));
    for (int a = 16'h0200; a < 16'h0300; a++)
      check(16'(dma_mem_model_inst.mem[a]), 16'(ref_mem[a]));
    rd(dma_pkg::ADDR_ARM, v);
    check(16'(v[ch]), 16'(md / 2));
    check(16'(irq_cnt - i0), 16'(ie));
    wr(dma_pkg::ADDR_FLAG, 8'h00);
    rd(dma_pkg::ADDR_FLAG, v);
    check(16'(v), 16'h0);
    if (md >= 2)
    begin
      wr(dma_pkg::ADDR_ARM, 8'h80 | (8'h01 << ch));
      rd(dma_pkg::ADDR_ARM, v);
      check(16'(v), 16'h0);
      w0 = wr_cnt;
      wr(dma_pkg::ADDR_REQ, 8'h01 << ch);
      repeat (20) @(posedge clk);
      check(16'(wr_cnt - w0), 16'h0);
    end
  endtask : run

  initial
  begin
    repeat (50000) @(posedge clk);
    bad_count++;
    print_verdict();
  end

  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 8; a++)
    begin
      rd(3'(a), v);
      check(16'(v), 16'(dma_pkg::REG_RESET));
    end
    wr(dma_pkg::ADDR_P0_HI, 8'h00);
    wr(dma_pkg::ADDR_P0_LO, 8'h40);
    wr(dma_pkg::ADDR_P1_HI, 8'h01);
    wr(dma_pkg::ADDR_P1_LO, 8'h00);
    run(0, 1, 0, 6, 1, 1, 1, 1, 0, 0);
    run(0, 1, 0, 5, 2, 3, 2, 0, 0, 0);
    run(1, 0, -1, 3, 3, 1, 0, 1, 0, 0);
    run(2, 2, -1, 2, 0, 2, 1, 1, 0, 0);
    run(3, 3, 0, 4, 1, 0, 2, 0, 0, 0);
    run(4, 1, 0, 1, 0, 0, 1, 1, 1, 0);
    run(3, 1, 0, 130, 1, 1, 1, 0, 0, 0);
    run(0, 1, 0, 3, 1, 1, 2, 0, 0, 1);
    run(1, 1, 0, 3, 1, 1, 1, 1, 0, 1);
    run(2, 1, 0, 3, 1, 1, 0, 0, 0, 1);
    print_verdict();
  end
endmodule : multichannel_dma_channel_engine_test
